// file: common/ard_pkg.sv
package ard_pkg;

    // ------------------------------------------------------------
    // Reserved operand codes and the pair code
    // ------------------------------------------------------------
    localparam logic [1:0] ARD_XY_RESERVED = 2'h2;
    localparam logic [2:0] ARD_EXT_RESERVED = 3'h6;
    localparam logic [2:0] ARD_UPPER_RESERVED = 3'h6;
    localparam logic [2:0] ARD_PAIR_CODE = 3'h6;

    // ------------------------------------------------------------
    // Register identities driven to the register file ports
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ARD_REG_NONE,
        ARD_REG_P,
        ARD_REG_Q_LOW,
        ARD_REG_Q_HIGH,
        ARD_REG_Q_PAIR,
        ARD_ACC_FIRST,
        ARD_ACC_SECOND,
        ARD_ACC_THIRD,
        ARD_ACC_FOURTH,
        ARD_UP_FIRST,
        ARD_UP_SECOND,
        ARD_UP_THIRD,
        ARD_UP_FOURTH,
        ARD_LO_FIRST,
        ARD_LO_SECOND,
        ARD_LO_THIRD,
        ARD_LO_FOURTH
    } ard_reg_type;

    // Instruction group that decides how the three-bit pair field reads
    typedef enum logic [1:0] {
        ARD_TRI_SHIFT,
        ARD_TRI_MIXED,
        ARD_TRI_OTHER
    } ard_tri_class_type;

    // Integer multiply group for the integer pair field
    typedef enum logic [1:0] {
        ARD_INT_MUL,
        ARD_INT_MAC,
        ARD_INT_MUL_ACC
    } ard_int_class_type;

    // ------------------------------------------------------------
    // Operand fields extracted from the instruction word
    // ------------------------------------------------------------
    typedef struct packed {
        logic accSel1;
        logic [1:0] srcSel2Xy;
        logic [1:0] accSel2;
        logic [2:0] regSel3Ext;
        logic [2:0] regSel3Wide;
        logic [2:0] accOrPairSel3;
        logic [2:0] upperWordSel3;
        logic [1:0] triPairSel2;
        logic [2:0] triPairSel3;
        logic [2:0] intPairSel3;
        ard_tri_class_type triClass;
        ard_int_class_type intClass;
    } ard_fields_type;

    typedef struct packed {
        ard_reg_type first;
        ard_reg_type second;
    } ard_pair_type;

    // ------------------------------------------------------------
    // Decoded selects and illegal-operand indications
    // ------------------------------------------------------------
    typedef struct packed {
        ard_reg_type accum1;
        ard_reg_type otherAccum;
        ard_reg_type srcXy;
        ard_reg_type accum2;
        ard_reg_type ext3;
        ard_reg_type wide3;
        ard_reg_type accOrPair3;
        ard_reg_type upperWord3;
        ard_pair_type pair2;
        ard_pair_type pair3;
        ard_pair_type intPair;
        logic illegalXy;
        logic illegalExt;
        logic illegalAccOrPair;
        logic illegalUpper;
        logic illegalAny;
    } ard_selects_type;

endpackage

// file: design/ard_operand_decoder.sv
module ard_operand_decoder
    import ard_pkg::*;
(
    // Clock and reset, used only to sample the checks below
    input logic clock,
    input logic rst,
    // Operand fields from pipeline control
    input ard_fields_type fields,
    // Register file selects
    output ard_selects_type selects
);

    // ------------------------------------------------------------
    // Lookup helpers
    // ------------------------------------------------------------
    // Index-based lookups keep the tables below short and uniform
    function automatic ard_reg_type accOf(input logic [1:0] idx);
        case (idx)
            2'h0: accOf = ARD_ACC_FIRST;
            2'h1: accOf = ARD_ACC_SECOND;
            2'h2: accOf = ARD_ACC_THIRD;
            default: accOf = ARD_ACC_FOURTH;
        endcase
    endfunction

    function automatic ard_reg_type upOf(input logic [1:0] idx);
        case (idx)
            2'h0: upOf = ARD_UP_FIRST;
            2'h1: upOf = ARD_UP_SECOND;
            2'h2: upOf = ARD_UP_THIRD;
            default: upOf = ARD_UP_FOURTH;
        endcase
    endfunction

    function automatic ard_reg_type loOf(input logic [1:0] idx);
        case (idx)
            2'h0: loOf = ARD_LO_FIRST;
            2'h1: loOf = ARD_LO_SECOND;
            2'h2: loOf = ARD_LO_THIRD;
            default: loOf = ARD_LO_FOURTH;
        endcase
    endfunction

    // Codes 100, 101 and 111 of the extended, wide and upper-word fields share one mapping
    function automatic ard_reg_type inputOf(input logic [2:0] code);
        case (code)
            3'h4: inputOf = ARD_REG_P;
            3'h5: inputOf = ARD_REG_Q_LOW;
            3'h7: inputOf = ARD_REG_Q_HIGH;
            default: inputOf = ARD_REG_NONE;
        endcase
    endfunction

    function automatic ard_pair_type mkPair(input ard_reg_type a, input ard_reg_type b);
        mkPair = '{first: a, second: b};
    endfunction

    // ------------------------------------------------------------
    // Pair tables: one three-bit table per instruction group, then the two-bit table
    // ------------------------------------------------------------
    function automatic ard_pair_type shiftPair(input logic [2:0] code);
        case (code)
            3'h0: shiftPair = mkPair(ARD_UP_THIRD, ARD_REG_Q_HIGH);
            3'h1: shiftPair = mkPair(ARD_UP_SECOND, ARD_REG_Q_HIGH);
            3'h2: shiftPair = mkPair(ARD_REG_Q_LOW, ARD_REG_Q_LOW);
            3'h3: shiftPair = mkPair(ARD_UP_FIRST, ARD_REG_Q_LOW);
            3'h4: shiftPair = mkPair(ARD_REG_Q_LOW, ARD_REG_P);
            3'h5: shiftPair = mkPair(ARD_REG_Q_HIGH, ARD_REG_P);
            3'h6: shiftPair = mkPair(ARD_UP_THIRD, ARD_REG_Q_LOW);
            default: shiftPair = mkPair(ARD_REG_Q_HIGH, ARD_REG_Q_LOW);
        endcase
    endfunction

    function automatic ard_pair_type mixedPair(input logic [2:0] code);
        case (code)
            3'h0: mixedPair = mkPair(ARD_REG_Q_HIGH, ARD_UP_THIRD);
            3'h1: mixedPair = mkPair(ARD_REG_Q_HIGH, ARD_UP_SECOND);
            3'h2: mixedPair = mkPair(ARD_REG_Q_LOW, ARD_REG_Q_LOW);
            3'h3: mixedPair = mkPair(ARD_REG_Q_LOW, ARD_UP_FIRST);
            3'h4: mixedPair = mkPair(ARD_REG_P, ARD_REG_Q_LOW);
            3'h5: mixedPair = mkPair(ARD_REG_P, ARD_REG_Q_HIGH);
            3'h6: mixedPair = mkPair(ARD_REG_Q_LOW, ARD_UP_THIRD);
            default: mixedPair = mkPair(ARD_REG_Q_LOW, ARD_REG_Q_HIGH);
        endcase
    endfunction

    // The general table mixes operand orders; it is not a swap of either
    function automatic ard_pair_type otherPair(input logic [2:0] code);
        case (code)
            3'h0: otherPair = mkPair(ARD_UP_THIRD, ARD_REG_Q_HIGH);
            3'h1: otherPair = mkPair(ARD_REG_Q_HIGH, ARD_UP_SECOND);
            3'h2: otherPair = mkPair(ARD_REG_Q_LOW, ARD_REG_Q_LOW);
            3'h3: otherPair = mkPair(ARD_REG_Q_LOW, ARD_UP_FIRST);
            3'h4: otherPair = mkPair(ARD_REG_P, ARD_REG_Q_LOW);
            3'h5: otherPair = mkPair(ARD_REG_P, ARD_REG_Q_HIGH);
            3'h6: otherPair = mkPair(ARD_UP_THIRD, ARD_REG_Q_LOW);
            default: otherPair = mkPair(ARD_REG_Q_LOW, ARD_REG_Q_HIGH);
        endcase
    endfunction

    function automatic ard_pair_type twoBitPair(input logic [1:0] code);
        case (code)
            2'h0: twoBitPair = mkPair(ARD_REG_Q_LOW, ARD_REG_P);
            2'h1: twoBitPair = mkPair(ARD_REG_Q_HIGH, ARD_REG_P);
            2'h2: twoBitPair = mkPair(ARD_UP_THIRD, ARD_REG_Q_LOW);
            default: twoBitPair = mkPair(ARD_REG_Q_HIGH, ARD_REG_Q_LOW);
        endcase
    endfunction

    // ------------------------------------------------------------
    // Single-register fields
    // ------------------------------------------------------------
    // No state anywhere: selects follow the fields in the same cycle
    wire xyReserved = (fields.srcSel2Xy == ARD_XY_RESERVED);
    wire extReserved = (fields.regSel3Ext == ARD_EXT_RESERVED);
    wire accOrPairReserved = fields.accOrPairSel3[2] && (fields.accOrPairSel3 != ARD_PAIR_CODE);
    wire upperReserved = (fields.upperWordSel3 == ARD_UPPER_RESERVED);
    ard_reg_type srcXySel;
    ard_reg_type ext3Sel;
    ard_reg_type wide3Sel;
    ard_reg_type accOrPairSel;
    ard_reg_type upperSel;

    assign srcXySel = (fields.srcSel2Xy == 2'h0) ? ARD_REG_P :
                      (fields.srcSel2Xy == 2'h1) ? ARD_REG_Q_LOW :
                      (fields.srcSel2Xy == 2'h3) ? ARD_REG_Q_HIGH : ARD_REG_NONE;
    assign ext3Sel = fields.regSel3Ext[2] ? inputOf(fields.regSel3Ext)
                                          : accOf(fields.regSel3Ext[1:0]);
    assign wide3Sel = !fields.regSel3Wide[2] ? accOf(fields.regSel3Wide[1:0]) :
                      (fields.regSel3Wide == ARD_PAIR_CODE) ? ARD_REG_Q_PAIR : inputOf(fields.regSel3Wide);
    assign accOrPairSel = !fields.accOrPairSel3[2] ? accOf(fields.accOrPairSel3[1:0]) :
                          (fields.accOrPairSel3 == ARD_PAIR_CODE) ? ARD_REG_Q_PAIR : ARD_REG_NONE;
    assign upperSel = fields.upperWordSel3[2] ? inputOf(fields.upperWordSel3)
                                              : upOf(fields.upperWordSel3[1:0]);

    // ------------------------------------------------------------
    // Pair fields
    // ------------------------------------------------------------
    // Integer pair: first index 0,0,0,0,1,1,2,2; second 0,1,2,3,2,3,2,3
    wire [1:0] intFirstIdx = fields.intPairSel3[2] ? (fields.intPairSel3[1] ? 2'h2 : 2'h1) : 2'h0;
    wire [1:0] intSecondIdx = fields.intPairSel3[2] ? {1'b1, fields.intPairSel3[0]} : fields.intPairSel3[1:0];
    ard_pair_type tri3Pair;
    ard_pair_type intPairSel;

    assign tri3Pair = (fields.triClass == ARD_TRI_SHIFT) ? shiftPair(fields.triPairSel3) :
                      (fields.triClass == ARD_TRI_MIXED) ? mixedPair(fields.triPairSel3) :
                      otherPair(fields.triPairSel3);
    assign intPairSel = (fields.intClass == ARD_INT_MUL) ? mkPair(upOf(intFirstIdx), loOf(intSecondIdx)) :
                        (fields.intClass == ARD_INT_MAC) ? mkPair(loOf(intFirstIdx), upOf(intSecondIdx)) :
                        mkPair(loOf(intFirstIdx), loOf(intSecondIdx));

    // ------------------------------------------------------------
    // Output assembly
    // ------------------------------------------------------------
    // A reserved field shows NONE and raises its own flag, so the
    // pipeline can trap only when the instruction really uses that field
    assign selects.accum1 = accOf({1'b0, fields.accSel1});
    assign selects.otherAccum = accOf({1'b0, ~fields.accSel1});
    assign selects.srcXy = srcXySel;
    assign selects.accum2 = accOf(fields.accSel2);
    assign selects.ext3 = ext3Sel;
    assign selects.wide3 = wide3Sel;
    assign selects.accOrPair3 = accOrPairSel;
    assign selects.upperWord3 = upperSel;
    assign selects.pair2 = twoBitPair(fields.triPairSel2);
    assign selects.pair3 = tri3Pair;
    assign selects.intPair = intPairSel;
    assign selects.illegalXy = xyReserved;
    assign selects.illegalExt = extReserved;
    assign selects.illegalAccOrPair = accOrPairReserved;
    assign selects.illegalUpper = upperReserved;
    assign selects.illegalAny = xyReserved | extReserved | accOrPairReserved | upperReserved;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_src_xy;
        @(posedge clock) disable iff (rst)
        (fields.srcSel2Xy == 2'h3) |-> (selects.srcXy == ARD_REG_Q_HIGH) && !selects.illegalXy;
    endproperty
    a_src_xy: assert property (p_src_xy) else $error("Two-bit source code 11 misdecoded");

    property p_other_acc;
        @(posedge clock) disable iff (rst)
        (selects.otherAccum != selects.accum1) && (selects.accum1 == (fields.accSel1 ? ARD_ACC_SECOND : ARD_ACC_FIRST));
    endproperty
    a_other_acc: assert property (p_other_acc) else $error("Opposite accumulator wrong");

    property p_acc2;
        @(posedge clock) disable iff (rst)
        (fields.accSel2 == 2'h2) |-> (selects.accum2 == ARD_ACC_THIRD);
    endproperty
    a_acc2: assert property (p_acc2) else $error("Two-bit accumulator code 10 misdecoded");

    property p_wide_pair;
        @(posedge clock) disable iff (rst)
        (fields.regSel3Wide == 3'h6) |-> (selects.wide3 == ARD_REG_Q_PAIR);
    endproperty
    a_wide_pair: assert property (p_wide_pair) else $error("Wide code 110 not q pair");

    property p_upper_word;
        @(posedge clock) disable iff (rst)
        (fields.upperWordSel3 == 3'h1) |-> (selects.upperWord3 == ARD_UP_SECOND);
    endproperty
    a_upper_word: assert property (p_upper_word) else $error("Upper word code 001 misdecoded");

    property p_pair2;
        @(posedge clock) disable iff (rst)
        (fields.triPairSel2 == 2'h2) |-> (selects.pair2 == mkPair(ARD_UP_THIRD, ARD_REG_Q_LOW));
    endproperty
    a_pair2: assert property (p_pair2) else $error("Two-bit pair code 10 misdecoded");

    property p_shift_pair;
        @(posedge clock) disable iff (rst)
        (fields.triClass == ARD_TRI_SHIFT && fields.triPairSel3 == 3'h3)
            |-> (selects.pair3 == mkPair(ARD_UP_FIRST, ARD_REG_Q_LOW));
    endproperty
    a_shift_pair: assert property (p_shift_pair) else $error("Shift pair code 011 misdecoded");

    property p_mixed_pair;
        @(posedge clock) disable iff (rst)
        (fields.triClass == ARD_TRI_MIXED && fields.triPairSel3 == 3'h0)
            |-> (selects.pair3 == mkPair(ARD_REG_Q_HIGH, ARD_UP_THIRD));
    endproperty
    a_mixed_pair: assert property (p_mixed_pair) else $error("Mixed pair code 000 misdecoded");

    property p_other_pair;
        @(posedge clock) disable iff (rst)
        (fields.triClass == ARD_TRI_OTHER && fields.triPairSel3 == 3'h1)
            |-> (selects.pair3 == mkPair(ARD_REG_Q_HIGH, ARD_UP_SECOND));
    endproperty
    a_other_pair: assert property (p_other_pair) else $error("Other pair code 001 misdecoded");

    property p_int_mul;
        @(posedge clock) disable iff (rst)
        (fields.intClass == ARD_INT_MUL && fields.intPairSel3 == 3'h7)
            |-> (selects.intPair == mkPair(ARD_UP_THIRD, ARD_LO_FOURTH));
    endproperty
    a_int_mul: assert property (p_int_mul) else $error("Integer multiply code 111 misdecoded");

    property p_int_mac;
        @(posedge clock) disable iff (rst)
        (fields.intClass == ARD_INT_MAC && fields.intPairSel3 == 3'h4)
            |-> (selects.intPair == mkPair(ARD_LO_SECOND, ARD_UP_THIRD));
    endproperty
    a_int_mac: assert property (p_int_mac) else $error("Integer accumulate code 100 misdecoded");

    property p_int_acc;
        @(posedge clock) disable iff (rst)
        (fields.intClass == ARD_INT_MUL_ACC && fields.intPairSel3 == 3'h3)
            |-> (selects.intPair == mkPair(ARD_LO_FIRST, ARD_LO_FOURTH));
    endproperty
    a_int_acc: assert property (p_int_acc) else $error("Integer lower pair code 011 misdecoded");

    property p_reserved;
        @(posedge clock) disable iff (rst)
        (fields.regSel3Ext == 3'h6)
            |-> selects.illegalExt && selects.illegalAny && (selects.ext3 == ARD_REG_NONE);
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved code not flagged");

    property p_aop_reserved;
        @(posedge clock) disable iff (rst)
        (fields.accOrPairSel3 == 3'h5)
            |-> selects.illegalAccOrPair && selects.illegalAny && (selects.accOrPair3 == ARD_REG_NONE);
    endproperty
    a_aop_reserved: assert property (p_aop_reserved) else $error("Pair-capable code 101 not flagged");

    property p_xy_reserved;
        @(posedge clock) disable iff (rst)
        (fields.srcSel2Xy == 2'h2) |-> selects.illegalXy && (selects.srcXy == ARD_REG_NONE);
    endproperty
    a_xy_reserved: assert property (p_xy_reserved) else $error("Two-bit source code 10 not refused");

    property p_upper_reserved;
        @(posedge clock) disable iff (rst)
        (fields.upperWordSel3 == 3'h6) |-> selects.illegalUpper && (selects.upperWord3 == ARD_REG_NONE);
    endproperty
    a_upper_reserved: assert property (p_upper_reserved) else $error("Upper word code 110 not refused");

    property p_ext_input;
        @(posedge clock) disable iff (rst)
        (fields.regSel3Ext == 3'h4) |-> (selects.ext3 == ARD_REG_P) && !selects.illegalExt;
    endproperty
    a_ext_input: assert property (p_ext_input) else $error("Extended code 100 misdecoded");

    property p_aop_pair;
        @(posedge clock) disable iff (rst)
        (fields.accOrPairSel3 == 3'h6) |-> (selects.accOrPair3 == ARD_REG_Q_PAIR) && !selects.illegalAccOrPair;
    endproperty
    a_aop_pair: assert property (p_aop_pair) else $error("Pair-capable code 110 not q pair");

    property p_same_cycle;
        @(posedge clock) disable iff (rst)
        $changed(fields.accSel2) |-> $changed(selects.accum2);
    endproperty
    a_same_cycle: assert property (p_same_cycle) else $error("Select lags its field");

endmodule

// file: testbench/ard_pipe_model.sv
module ard_pipe_model
    import ard_pkg::*;
(
    // Clock and reset
    input logic clock,
    input logic rst,
    // Next instruction fields from the bench
    input ard_fields_type nextFields,
    // Fields presented to the decoder
    output ard_fields_type fields
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Pipeline control stage
    // ------------------------------------------------------------
    ard_fields_type fields_reg;

    // One new instruction word per clock; reset clears to an all-zero word,
    // which is legal in every field, so no stray illegal flag shows in reset
    always_ff @(posedge clock) begin
        if (rst) begin
            fields_reg <= '0;
        end else begin
            fields_reg <= nextFields;
        end
    end

    assign fields = fields_reg;
endmodule

// file: testbench/ard_operand_decoder_bench.sv
module ard_operand_decoder_bench
    import ard_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals, counters and expectation tables
    // ------------------------------------------------------------
    logic clock;
    logic rst;
    ard_fields_type nextFields;
    ard_fields_type fields;
    ard_selects_type selects;
    int numErrors;
    int numChecks;
    ard_reg_type accTab[4] = '{ARD_ACC_FIRST, ARD_ACC_SECOND, ARD_ACC_THIRD, ARD_ACC_FOURTH};
    ard_reg_type upTab[4] = '{ARD_UP_FIRST, ARD_UP_SECOND, ARD_UP_THIRD, ARD_UP_FOURTH};
    ard_reg_type loTab[4] = '{ARD_LO_FIRST, ARD_LO_SECOND, ARD_LO_THIRD, ARD_LO_FOURTH};
    // Index into srcTab: 0 p, 1 q_low, 2 q_high, 3 third upper, 4 second upper, 5 first upper
    ard_reg_type srcTab[6] = '{ARD_REG_P, ARD_REG_Q_LOW, ARD_REG_Q_HIGH, ARD_UP_THIRD, ARD_UP_SECOND, ARD_UP_FIRST};
    int p2First[4] = '{1, 2, 3, 2};
    int p2Second[4] = '{0, 0, 1, 1};
    // Rows: shift group, mixed-sign multiply, all other three-operand
    int triFirst[3][8] = '{'{3, 4, 1, 5, 1, 2, 3, 2}, '{2, 2, 1, 1, 0, 0, 1, 1}, '{3, 2, 1, 1, 0, 0, 3, 1}};
    int triSecond[3][8] = '{'{2, 2, 1, 1, 0, 0, 1, 1}, '{3, 4, 1, 5, 1, 2, 3, 2}, '{2, 4, 1, 5, 1, 2, 1, 2}};
    int intA[8] = '{0, 0, 0, 0, 1, 1, 2, 2};
    int intB[8] = '{0, 1, 2, 3, 2, 3, 2, 3};

    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    ard_pipe_model u_ard_pipe_model (.clock(clock), .rst(rst), .nextFields(nextFields), .fields(fields));
    ard_operand_decoder u_ard_operand_decoder (.clock(clock), .rst(rst), .fields(fields), .selects(selects));

    // ------------------------------------------------------------
    // Compare, drive and closing tasks
    // ------------------------------------------------------------
    task automatic chkReg(input ard_reg_type got, input ard_reg_type exp, input string what);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD at %0t: %s got %s expected %s", $time, what, got.name(), exp.name());
        end
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        numChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // Fields reach the decoder one edge after the request; judged at the falling edge
    task automatic apply(input ard_fields_type f);
        @(posedge clock);
        nextFields <= f;
        @(posedge clock);
        @(negedge clock);
    endtask

    task automatic endSim();
        $display("Checks: %0d, errors: %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic testSrcXy();
        ard_fields_type f;
        for (int v = 0; v < 4; v++) begin
            f = '0;
            f.srcSel2Xy = 2'(v);
            apply(f);
            chkReg(selects.srcXy, (v == 2) ? ARD_REG_NONE : srcTab[(v == 3) ? 2 : v], "srcXy");
            chkBit(selects.illegalXy, v == 2, "illegalXy");
            chkBit(selects.illegalAny, v == 2, "illegalAny");
        end
    endtask

    task automatic testAccums();
        ard_fields_type f;
        for (int v = 0; v < 4; v++) begin
            f = '0;
            f.accSel1 = 1'(v);
            f.accSel2 = 2'(v);
            apply(f);
            chkReg(selects.accum1, accTab[v & 1], "accum1");
            chkReg(selects.otherAccum, accTab[1 - (v & 1)], "otherAccum");
            chkReg(selects.accum2, accTab[v], "accum2");
        end
    endtask

    // All four three-bit fields carry the same code, so reserved codes overlap
    task automatic testSel3();
        ard_fields_type f;
        ard_reg_type inReg;
        for (int v = 0; v < 8; v++) begin
            f = '0;
            f.regSel3Ext = 3'(v);
            f.regSel3Wide = 3'(v);
            f.accOrPairSel3 = 3'(v);
            f.upperWordSel3 = 3'(v);
            inReg = srcTab[(v == 7) ? 2 : (v & 1)];
            apply(f);
            chkReg(selects.ext3, v < 4 ? accTab[v & 3] : (v == 6 ? ARD_REG_NONE : inReg), "ext3");
            chkReg(selects.wide3, v < 4 ? accTab[v & 3] : (v == 6 ? ARD_REG_Q_PAIR : inReg), "wide3");
            chkReg(selects.accOrPair3, v < 4 ? accTab[v & 3] : (v == 6 ? ARD_REG_Q_PAIR : ARD_REG_NONE), "aop3");
            chkReg(selects.upperWord3, v < 4 ? upTab[v & 3] : (v == 6 ? ARD_REG_NONE : inReg), "upper3");
            chkBit(selects.illegalExt, v == 6, "illegalExt");
            chkBit(selects.illegalUpper, v == 6, "illegalUpper");
            chkBit(selects.illegalAccOrPair, v >= 4 && v != 6, "illegalAccOrPair");
            chkBit(selects.illegalAny, v >= 4, "illegalAny");
        end
    endtask

    task automatic testPairs();
        ard_fields_type f;
        for (int c = 0; c < 3; c++) begin
            for (int v = 0; v < 8; v++) begin
                f = '0;
                f.triClass = ard_tri_class_type'(c);
                f.intClass = ard_int_class_type'(c);
                f.triPairSel3 = 3'(v);
                f.intPairSel3 = 3'(v);
                f.triPairSel2 = 2'(v);
                apply(f);
                chkReg(selects.pair3.first, srcTab[triFirst[c][v]], "pair3 first");
                chkReg(selects.pair3.second, srcTab[triSecond[c][v]], "pair3 second");
                chkReg(selects.intPair.first, c == 0 ? upTab[intA[v]] : loTab[intA[v]], "int first");
                chkReg(selects.intPair.second, c == 1 ? upTab[intB[v]] : loTab[intB[v]], "int second");
                chkReg(selects.pair2.first, srcTab[p2First[v & 3]], "pair2 first");
                chkReg(selects.pair2.second, srcTab[p2Second[v & 3]], "pair2 second");
            end
        end
    endtask

    // A new word every clock: the decode must follow within the same cycle
    task automatic testBackToBack();
        ard_fields_type f1;
        ard_fields_type f2;
        f1 = '0;
        f1.srcSel2Xy = 2'h2;
        f2 = '0;
        f2.intClass = ARD_INT_MAC;
        f2.intPairSel3 = 3'h4;
        @(posedge clock);
        nextFields <= f1;
        @(posedge clock);
        nextFields <= f2;
        @(negedge clock);
        chkBit(selects.illegalAny, 1'h1, "b2b illegalAny");
        @(negedge clock);
        chkBit(selects.illegalAny, 1'h0, "b2b illegalAny");
        chkReg(selects.intPair.first, ARD_LO_SECOND, "b2b int first");
        chkReg(selects.intPair.second, ARD_UP_THIRD, "b2b int second");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst = 1'h1;
        nextFields = '0;
        numErrors = 0;
        numChecks = 0;
        repeat (6) @(posedge clock);
        rst <= 1'h0;
        testSrcXy();
        testAccums();
        testSel3();
        testPairs();
        testBackToBack();
        endSim();
    end

    // The run needs about ninety cycles; a hang past this bound is a failure
    initial begin
        repeat (2000) @(posedge clock);
        numErrors++;
        endSim();
    end
endmodule
